// >>> design/ips_ctrl.sv
// interrupt request logic: per-source priority, delayed level rewrite,
// external pin level/edge sensing, timer mode-switch flags, and a
// wishbone register file with a sticky status/mask interrupt line.
// assumes a classic wishbone master and a core that acknowledges the
// presented request with irq_ack_i and the accepted source number.
`timescale 1ns/1ps
`include "ips_map.svh"

module ips_ctrl
  import ips_pkg::*;
#(
  parameter int NTMR = 5,
  parameter int NEXT = 3
)
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // request sources
  input wire logic [NEXT-1:0] ext_irq_pin_i,
  input wire logic [NTMR-1:0] timer_evt_i,
  // core request and acceptance
  output logic irq_req_o,
  output ips_level_t irq_level_o,
  output logic [2:0] irq_id_o,
  input wire logic irq_ack_i,
  input wire logic [2:0] irq_ack_id_i,
  // summary interrupt
  output logic irq_o
);
  localparam int NSRC = NTMR + NEXT;

  // -----------------------------------------------------------------------
  // state
  // -----------------------------------------------------------------------
  ips_dtime_e dtime;
  logic [2*NTMR-1:0] tmode;
  logic [NSRC-1:0] stat;
  logic [NSRC-1:0] mask;
  ips_level_t wr_lvl [NSRC];
  ips_level_t eff_lvl [NSRC];
  logic [2:0] dly_cnt [NSRC];
  logic [NSRC-1:0] flag;
  logic [NEXT-1:0] sense;
  logic [NEXT-1:0] pol;
  logic [NEXT-1:0] pin_s;
  logic [NEXT-1:0] pin_d;
  logic [NSRC-1:0] raw_prev;
  logic ack;
  logic [31:0] rd_q;

  ips_arb_if #(.NSRC(NSRC), .IDW(3)) arb_bus ();

  // -----------------------------------------------------------------------
  // bus decode; a write lands on the edge where ack is seen high
  // -----------------------------------------------------------------------
  wire [5:0] word = wb_adr_i[7:2];
  wire req_now = wb_cyc_i & wb_stb_i;
  wire wr_go = req_now & wb_we_i & ack & wb_sel_i[0];
  wire wr_hi = req_now & wb_we_i & ack & wb_sel_i[1];
  wire wr_mode = wr_go & (word == `IPS_ADR_MODE);
  wire wr_tmode = wr_go & (word == `IPS_ADR_TMODE);
  wire wr_tmode_hi = wr_hi & (word == `IPS_ADR_TMODE);
  wire wr_stat = wr_go & (word == `IPS_ADR_STAT);
  wire wr_mask = wr_go & (word == `IPS_ADR_MASK);
  wire [5:0] icr_idx = word - `IPS_ADR_ICR0;
  wire icr_hit = (word >= `IPS_ADR_ICR0) &&
    (icr_idx < 6'(NSRC));
  wire wr_icr = wr_go & icr_hit;
  wire [7:0] wd = wb_dat_i[7:0];
  wire [1:0] wd_dt = wd[`IPS_MODE_DT_HI:`IPS_MODE_DT_LO];
  wire ips_level_t wd_lvl = wd[`IPS_ICR_LVL_HI:`IPS_ICR_LVL_LO];

  // -----------------------------------------------------------------------
  // new timer mode word from byte lanes zero and one
  // -----------------------------------------------------------------------
  wire [2*NTMR-1:0] tmode_new =
    {(wr_tmode_hi ? wb_dat_i[2*NTMR-1:8] : tmode[2*NTMR-1:8]),
     (wr_tmode ? wd : tmode[7:0])};

  // -----------------------------------------------------------------------
  // per-source event terms
  // -----------------------------------------------------------------------
  logic [NSRC-1:0] set_ev;
  logic [NSRC-1:0] clr_ev;
  logic [NSRC-1:0] raw_req;
  logic [NSRC-1:0] icr_sel;
  logic [NSRC-1:0] accepted;
  logic [NEXT-1:0] active;
  logic [NEXT-1:0] edge_hit;

  // pin polarity: pol=1 active high / rising, pol=0 active low / falling
  assign active = ~(pin_s ^ pol);
  assign edge_hit = (pin_s ^ pin_d) & active;

  always_comb
  begin
    for (int i = 0; i < NSRC; i++)
    begin
      icr_sel[i] = wr_icr && (icr_idx == 6'(i));
      accepted[i] = irq_ack_i && (irq_ack_id_i == 3'(i));
      clr_ev[i] = accepted[i] |
        (icr_sel[i] & ~wd[`IPS_ICR_REQ]);
      if (i < NTMR)
      begin
        // a timer event, or a switch from timer/event counting into
        // one-shot or pwm, raises the channel flag
        set_ev[i] = timer_evt_i[i] |
          (~tmode[2*i+`IPS_TMODE_ONE_SHOT_BIT] &
           tmode_new[2*i+`IPS_TMODE_ONE_SHOT_BIT]);
        raw_req[i] = flag[i];
      end
      else
      begin
        // edges latch even in level mode, so the flag may be stale when
        // software returns to edge sensing and must be cleared first
        set_ev[i] = edge_hit[i-NTMR];
        // level mode follows the pin live; the latched flag is not consulted
        raw_req[i] = sense[i-NTMR] ? active[i-NTMR]
                                   : flag[i];
      end
      set_ev[i] = set_ev[i] | (icr_sel[i] & wd[`IPS_ICR_REQ]);
      // a zero level keeps the source from competing
      arb_bus.req[i] = raw_req[i] && (eff_lvl[i] != `IPS_RST_LVL);
      arb_bus.level[i] = eff_lvl[i];
    end
  end

  // -----------------------------------------------------------------------
  // read mux; unmapped words read as zero and still acknowledge
  // -----------------------------------------------------------------------
  logic [31:0] rd_data;
  always_comb
  begin
    rd_data = '0;
    if (word == `IPS_ADR_MODE)
    begin
      rd_data[`IPS_MODE_DT_HI:`IPS_MODE_DT_LO] = dtime;
    end
    else if (word == `IPS_ADR_TMODE)
    begin
      rd_data[2*NTMR-1:0] = tmode;
    end
    else if (word == `IPS_ADR_STAT)
    begin
      rd_data[NSRC-1:0] = stat;
    end
    else if (word == `IPS_ADR_MASK)
    begin
      rd_data[NSRC-1:0] = mask;
    end
    else if (icr_hit)
    begin
      for (int i = 0; i < NSRC; i++)
      begin
        if (icr_idx == 6'(i))
        begin
          rd_data[`IPS_ICR_LVL_HI:`IPS_ICR_LVL_LO] = wr_lvl[i];
          rd_data[`IPS_ICR_REQ] = flag[i];
          if (i >= NTMR)
          begin
            rd_data[`IPS_ICR_SENSE] = sense[i-NTMR];
            rd_data[`IPS_ICR_POL] = pol[i-NTMR];
          end
        end
      end
    end
  end

  // -----------------------------------------------------------------------
  // wishbone answer: one wait state, ack dropped the cycle after
  // -----------------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack <= 1'b0;
      rd_q <= '0;
    end
    else
    begin
      ack <= req_now & ~ack;
      rd_q <= rd_data;
    end
  end

  assign wb_ack_o = ack;
  assign wb_dat_o = rd_q;

  // -----------------------------------------------------------------------
  // global control registers
  // -----------------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      dtime <= IPS_DT2;
      tmode <= `IPS_RST_TMODE;
      mask <= '0;
    end
    else
    begin
      if (wr_mode)
      begin
        dtime <= ips_dtime_e'(wd_dt);
      end
      tmode <= tmode_new;
      if (wr_mask)
      begin
        mask <= wd[NSRC-1:0];
      end
    end
  end

  // -----------------------------------------------------------------------
  // sticky status: a new rising request sets, write-one clears, set wins
  // -----------------------------------------------------------------------
  wire [NSRC-1:0] stat_set = raw_req & ~raw_prev;
  wire [NSRC-1:0] stat_clr = wr_stat ? wd[NSRC-1:0] : '0;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      stat <= '0;
      raw_prev <= '0;
    end
    else
    begin
      stat <= stat_set | (stat & ~stat_clr);
      raw_prev <= raw_req;
    end
  end

  assign irq_o = |(stat & mask);

  // -----------------------------------------------------------------------
  // request flags: a set in the same cycle as a clear wins
  // -----------------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      flag <= '0;
    end
    else
    begin
      flag <= set_ev | (flag & ~clr_ev);
    end
  end

  // -----------------------------------------------------------------------
  // external sense configuration and previous pin value
  // -----------------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sense <= '0;
      pol <= '0;
      pin_d <= '1;
    end
    else
    begin
      pin_d <= pin_s;
      for (int j = 0; j < NEXT; j++)
      begin
        if (icr_sel[NTMR+j])
        begin
          sense[j] <= wd[`IPS_ICR_SENSE];
          pol[j] <= wd[`IPS_ICR_POL];
        end
      end
    end
  end

  // -----------------------------------------------------------------------
  // priority rewrite: the written level waits out the detection window
  // so a pending compare never sees a half-updated value
  // -----------------------------------------------------------------------
  wire [2:0] rw_dly = ips_rewrite_delay(dtime);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      for (int i = 0; i < NSRC; i++)
      begin
        wr_lvl[i] <= `IPS_RST_LVL;
        eff_lvl[i] <= `IPS_RST_LVL;
        dly_cnt[i] <= 3'h0;
      end
    end
    else
    begin
      for (int i = 0; i < NSRC; i++)
      begin
        if (icr_sel[i])
        begin
          wr_lvl[i] <= wd_lvl;
          dly_cnt[i] <= rw_dly;
        end
        else if (dly_cnt[i] != 3'h0)
        begin
          dly_cnt[i] <= dly_cnt[i] - 3'h1;
        end
        if (!icr_sel[i] && (dly_cnt[i] == 3'h1))
        begin
          eff_lvl[i] <= wr_lvl[i];
        end
      end
    end
  end

  // -----------------------------------------------------------------------
  // presented request; registered, so it trails an acceptance by a cycle
  // -----------------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      irq_req_o <= 1'b0;
      irq_level_o <= `IPS_RST_LVL;
      irq_id_o <= 3'h0;
    end
    else
    begin
      irq_req_o <= arb_bus.win;
      irq_level_o <= arb_bus.win_level;
      irq_id_o <= arb_bus.win_id;
    end
  end

  // -----------------------------------------------------------------------
  // submodules
  // -----------------------------------------------------------------------
  ips_sync #(.W(NEXT)) u_sync
  (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i(ext_irq_pin_i),
    .pin_o(pin_s)
  );

  ips_arbiter #(.NSRC(NSRC), .IDW(3)) u_arb
  (
    .a(arb_bus)
  );
endmodule

// >>> common/ips_map.svh
// register map, field positions, reset values and delay counts for the
// interrupt priority and external sense block; pure definitions only.
// assumes a wishbone word bus with byte addresses on adr[7:0].
//
// Behaviour
// - new priority level acts after 1-4 cycles
// - mode register bits 5,4 choose detection time
// - level zero disables; levels one-seven enable
// - level-sense flag is not a latched pending bit (here the flag still latches pin edges in level mode)
// - level-sense request dropped when pin goes inactive
// - level-sense pin still active re-raises interrupt
// - sense bit zero selects edge sensing
// - timer switch to one-shot/pwm sets request flag
`ifndef IPS_MAP_SVH
`define IPS_MAP_SVH

// -----------------------------------------------------------------------
// word addresses (byte address divided by four)
// -----------------------------------------------------------------------
`define IPS_ADR_MODE 6'h00
`define IPS_ADR_TMODE 6'h01
`define IPS_ADR_STAT 6'h02
`define IPS_ADR_MASK 6'h03
`define IPS_ADR_ICR0 6'h04

// -----------------------------------------------------------------------
// field positions
// -----------------------------------------------------------------------
`define IPS_ICR_LVL_LO 0
`define IPS_ICR_LVL_HI 2
`define IPS_ICR_REQ 3
`define IPS_ICR_SENSE 4
`define IPS_ICR_POL 5
`define IPS_MODE_DT_LO 4
`define IPS_MODE_DT_HI 5
`define IPS_TMODE_ONE_SHOT_BIT 1

// -----------------------------------------------------------------------
// reset values and priority rewrite delays in cycles
// -----------------------------------------------------------------------
`define IPS_RST_LVL 3'h0
`define IPS_RST_BYTE 8'h00
`define IPS_RST_TMODE 10'h000
`define IPS_DLY_DT2 3'h1
`define IPS_DLY_DT4 3'h2
`define IPS_DLY_DT7 3'h4

`endif

// >>> common/ips_pkg.sv
// types shared by the interrupt priority block and its arbiter.
// assumes ips_map.svh supplies all numeric constants.
`include "ips_map.svh"

package ips_pkg;

  typedef logic [2:0] ips_level_t;

  // detection time select, gray along 2 -> 4 -> 7 cycles
  typedef enum logic [1:0]
  {
    IPS_DT2 = 2'h0,
    IPS_DT4 = 2'h1,
    IPS_DT7 = 2'h3,
    IPS_DT_RSV = 2'h2
  } ips_dtime_e;

  // timer channel operating modes
  typedef enum logic [1:0]
  {
    IPS_TM_TIMER = 2'h0,
    IPS_TM_EVENT = 2'h1,
    IPS_TM_ONE_SHOT = 2'h2,
    IPS_TM_PWM = 2'h3
  } ips_tmode_e;

  // cycles from a level write until the new level acts
  function automatic logic [2:0] ips_rewrite_delay(input ips_dtime_e dt);
    logic [2:0] d;
    d = `IPS_DLY_DT7;
    if (dt == IPS_DT2)
    begin
      d = `IPS_DLY_DT2;
    end
    else if (dt == IPS_DT4)
    begin
      d = `IPS_DLY_DT4;
    end
    return d;
  endfunction

endpackage

// >>> common/ips_arb_if.sv
// carries per-source requests and levels to the arbiter and the winner
// back; assumes both ends share one clock and no timing in between.
`timescale 1ns/1ps

interface ips_arb_if
  import ips_pkg::*;
#(
  parameter int NSRC = 8,
  parameter int IDW = 3
);
  logic [NSRC-1:0] req;
  ips_level_t level [NSRC];
  logic win;
  ips_level_t win_level;
  logic [IDW-1:0] win_id;

  modport ctl (output req, output level, input win, input win_level,
    input win_id);
  modport arb (input req, input level, output win, output win_level,
    output win_id);
endinterface

// >>> design/ips_sync.sv
// three-stage synchroniser for asynchronous request pins.
// assumes pins may change at any time relative to clk_i.
`timescale 1ns/1ps

module ips_sync
#(
  parameter int W = 3
)
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // pins and filtered result
  input wire logic [W-1:0] pin_i,
  output logic [W-1:0] pin_o
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;
  wire [W-1:0] agree = ~(s2 ^ s3);

  // -----------------------------------------------------------------------
  // chain; a change is taken once stages two and three agree
  // -----------------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s1 <= '1;
      s2 <= '1;
      s3 <= '1;
      pin_o <= '1;
    end
    else
    begin
      s1 <= pin_i;
      s2 <= s1;
      s3 <= s2;
      pin_o <= (s3 & agree) | (pin_o & ~agree); // hold while they differ
    end
  end
endmodule

// >>> design/ips_arbiter.sv
// picks the highest-level pending source; lowest index wins a tie.
// assumes requests already carry level-zero masking from the caller.
`timescale 1ns/1ps
`include "ips_map.svh"

module ips_arbiter
  import ips_pkg::*;
#(
  parameter int NSRC = 8,
  parameter int IDW = 3
)
(
  // arbitration carrier
  ips_arb_if.arb a
);
  // -----------------------------------------------------------------------
  // search from the top index down so a lower index overrides on a tie
  // -----------------------------------------------------------------------
  always_comb
  begin
    a.win = 1'b0;
    a.win_level = `IPS_RST_LVL;
    a.win_id = '0;
    for (int i = NSRC - 1; i >= 0; i--)
    begin
      if (a.req[i] && (a.level[i] >= a.win_level))
      begin
        a.win = 1'b1;
        a.win_level = a.level[i];
        a.win_id = IDW'(i);
      end
    end
  end
endmodule

// >>> testbench/ips_ctrl_properties.sv
// concurrent checks on the ports of ips_ctrl.
// assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ps

module ips_ctrl_properties
  import ips_pkg::*;
#(
  parameter int NTMR = 5,
  parameter int NEXT = 3
)
(
  // clock, reset and bus
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // interrupt side
  input wire logic irq_req_o,
  input wire ips_level_t irq_level_o,
  input wire logic irq_o
);
  // -------------------------------------------------------------------
  // bus and request properties
  // -------------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // a request is taken only while no answer is standing
  wire take = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire mask_zero = take && wb_we_i && wb_sel_i[0] && wb_adr_i == 8'h0C
    && wb_dat_i[7:0] == 8'h00;

  property p_ack_next;
    take |=> wb_ack_o;
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack missing");

  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");

  property p_ack_cause;
    !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o;
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("stray ack");

  // reset itself is the cause here, so this one is never disabled
  property p_rst_quiet;
    disable iff (1'b0)
    rst_i |=> !wb_ack_o && !irq_req_o && !irq_o && wb_dat_o == 32'h0;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("reset not quiet");

  property p_upper_zero;
    wb_ack_o |-> wb_dat_o[31:10] == 22'h0;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("upper bits set");

  property p_unmapped;
    take && !wb_we_i && wb_adr_i == 8'hFC |=> wb_dat_o == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped data");

  property p_mask_off;
    mask_zero |=> ##1 !irq_o;
  endproperty
  a_mask_off: assert property (p_mask_off) else $error("irq not masked");

  property p_req_level;
    irq_req_o |-> irq_level_o != 3'h0;
  endproperty
  a_req_level: assert property (p_req_level)
    else $error("level 0 req");

  // main scenarios reached
  c_req: cover property (irq_req_o && irq_level_o == 3'h5);
  c_irq: cover property (irq_o);
  c_unmapped: cover property (take && wb_adr_i == 8'hFC);
endmodule

bind ips_ctrl ips_ctrl_properties #(.NTMR(NTMR), .NEXT(NEXT)) u_props (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .irq_req_o(irq_req_o), .irq_level_o(irq_level_o), .irq_o(irq_o));

// >>> testbench/ips_partner.sv
// model of the external request pins and of the core that accepts.
// assumes pins are active low with a pull-up when nobody drives them.
`timescale 1ns/1ps

module ips_partner
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // commands from the bench
  input wire logic [2:0] pin_cmd_i,
  input wire logic ack_en_i,
  // core side
  input wire logic irq_req_i,
  input wire logic [2:0] irq_id_i,
  output logic [2:0] ext_irq_pin_o,
  output logic irq_ack_o,
  output logic [2:0] irq_ack_id_o,
  output logic [3:0] n_ack_o
);
  logic [1:0] gap;

  // released pins float back to the pulled-up inactive level
  assign ext_irq_pin_o = ~pin_cmd_i;

  // accept one request, then wait out the stale registered request
  always_ff @(posedge clk_i)
  begin
    irq_ack_o <= 1'b0;
    if (rst_i)
    begin
      gap <= 2'h0;
      n_ack_o <= 4'h0;
      irq_ack_id_o <= 3'h0;
    end
    else if (gap != 2'h0)
    begin
      gap <= gap - 2'h1;
    end
    else if (ack_en_i && irq_req_i)
    begin
      irq_ack_o <= 1'b1;
      irq_ack_id_o <= irq_id_i;
      gap <= 2'h3;
      n_ack_o <= n_ack_o + 4'h1;
    end
  end
endmodule

// >>> testbench/tb.sv
// self-checking bench for ips_ctrl with the pin and core model beside it.
// assumes the package and the property checker are compiled first.
`timescale 1ns/1ps

module tb
  import ips_pkg::*;
;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'hF;
  logic [3:0] sel_w = 4'hF;
  logic [31:0] dw = 32'h0;
  logic [31:0] dr;
  logic ack;
  logic [2:0] pins;
  logic [4:0] tevt = 5'h00;
  logic req;
  ips_level_t lvl;
  logic [2:0] id;
  logic iack;
  logic [2:0] iack_id;
  logic irq;
  logic [2:0] pin_cmd = 3'h0;
  logic ack_en = 1'b0;
  logic [3:0] n_ack;
  int n_fail = 0;
  int n_tests = 0;

  always #25 clk_i = ~clk_i;

  ips_ctrl u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(dw), .wb_dat_o(dr), .wb_ack_o(ack), .ext_irq_pin_i(pins),
    .timer_evt_i(tevt), .irq_req_o(req), .irq_level_o(lvl),
    .irq_id_o(id), .irq_ack_i(iack), .irq_ack_id_i(iack_id), .irq_o(irq));

  ips_partner u_partner (.clk_i(clk_i), .rst_i(rst_i), .pin_cmd_i(pin_cmd),
    .ack_en_i(ack_en), .irq_req_i(req), .irq_id_i(id),
    .ext_irq_pin_o(pins), .irq_ack_o(iack), .irq_ack_id_o(iack_id),
    .n_ack_o(n_ack));

  // -------------------------------------------------------------------
  // shared tasks
  // -------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
    input string what);
    n_tests++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // one classic cycle; idle edge first so cyc is low for a cycle
  task automatic bus(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dw <= d;
    sel <= sel_w;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack !== 1'b1 && n < 50);
    chk(n < 50, 1'b1, "bus answer");
    q = dr;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
    input string what);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, e, what);
  endtask

  // bounded wait for the request line to reach a level
  task automatic wait_req(input logic v, output int c);
    c = 0;
    while (req !== v && c < 20)
    begin
      @(posedge clk_i);
      c++;
    end
    // a wait that runs out is a mismatch of its own
    chk(req === v, 1'b1, "wait limit");
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // -------------------------------------------------------------------
  // scenarios
  // -------------------------------------------------------------------
  task automatic t_reset();
    logic [7:0] a [7];
    a = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h24, 8'hFC};
    chk({req, irq}, 2'h0, "outputs idle");
    foreach (a[i])
      rd(a[i], 32'h0, "reset value");
    wr(8'hFC, 32'hFF);
    rd(8'hFC, 32'h0, "unmapped");
    $display("test reset done");
  endtask

  task automatic t_edge();
    int c;
    wr(8'h24, 32'h03);
    pin_cmd <= 3'h1;
    repeat (3) @(posedge clk_i);
    pin_cmd <= 3'h0;
    wait_req(1'b1, c);
    repeat (8) @(posedge clk_i);
    chk({req, id, lvl}, 7'h6B, "edge kept");
    chk(irq, 1'b0, "masked");
    rd(8'h08, 32'h20, "status");
    wr(8'h0C, 32'h20);
    @(posedge clk_i);
    chk(irq, 1'b1, "unmasked");
    ack_en <= 1'b1;
    wait_req(1'b0, c);
    chk(c < 6, 1'b1, "accepted");
    ack_en <= 1'b0;
    rd(8'h24, 32'h03, "flag gone");
    wr(8'h08, 32'h20);
    @(posedge clk_i);
    chk(irq, 1'b0, "status cleared");
    wr(8'h0C, 32'h00);
    // active-high polarity: a falling pin is ignored, a rising one latches
    wr(8'h2C, 32'h23);
    pin_cmd <= 3'h4;
    repeat (8) @(posedge clk_i);
    rd(8'h2C, 32'h23, "fall ignored");
    pin_cmd <= 3'h0;
    repeat (8) @(posedge clk_i);
    rd(8'h2C, 32'h2B, "rise latched");
    chk({req, id, lvl}, 7'h7B, "rising source");
    wr(8'h2C, 32'h20);
    $display("test edge done");
  endtask

  task automatic t_level();
    int c;
    wr(8'h28, 32'h12);
    pin_cmd <= 3'h2;
    wait_req(1'b1, c);
    chk(id, 3'h6, "level source");
    pin_cmd <= 3'h0;
    wait_req(1'b0, c);
    repeat (8) @(posedge clk_i);
    chk(req, 1'b0, "not retained");
    pin_cmd <= 3'h2;
    ack_en <= 1'b1;
    repeat (16) @(posedge clk_i);
    chk(req, 1'b1, "raised again");
    chk(n_ack > 4'h2, 1'b1, "served twice");
    pin_cmd <= 3'h0;
    ack_en <= 1'b0;
    wr(8'h28, 32'h10);
    wr(8'h28, 32'h00);
    wr(8'h28, 32'h00);
    wr(8'h28, 32'h02);
    repeat (8) @(posedge clk_i);
    chk(req, 1'b0, "no stale edge");
    $display("test level done");
  endtask

  task automatic t_timer();
    wr(8'h08, 32'hFF);
    // lane one off: channel four mode bits must not move
    sel_w = 4'h1;
    wr(8'h04, 32'h3FF);
    sel_w = 4'hF;
    rd(8'h04, 32'h0FF, "lane one off");
    wr(8'h04, 32'h010);
    wr(8'h04, 32'h0EE);
    rd(8'h04, 32'h0EE, "timer modes");
    for (int i = 0; i < 5; i++)
      rd(8'h10 + 8'(4 * i), (i < 4) ? 32'h08 : 32'h0, "mode flag");
    rd(8'h08, 32'h0F, "timer status");
    for (int i = 0; i < 5; i++)
      wr(8'h10 + 8'(4 * i), 32'h0);
    rd(8'h10, 32'h0, "flag cleared");
    wr(8'h04, 32'h000);
    $display("test timer done");
  endtask

  task automatic t_delay();
    int lat [4];
    ips_dtime_e dts [4];
    dts = '{IPS_DT2, IPS_DT4, IPS_DT7, IPS_DT_RSV};
    for (int i = 0; i < 4; i++)
    begin
      wr(8'h00, {26'h0, dts[i], 4'h0});
      tevt <= 5'h10;
      @(posedge clk_i);
      tevt <= 5'h00;
      repeat (6) @(posedge clk_i);
      chk(req, 1'b0, "level zero off");
      wr(8'h20, 32'h0D);
      wait_req(1'b1, lat[i]);
      chk({id, lvl}, 6'h25, "winner");
      wr(8'h20, 32'h0);
    end
    chk(32'(lat[1] - lat[0]), 32'h1, "delay dt4");
    chk(32'(lat[2] - lat[0]), 32'h3, "delay dt7");
    chk(32'(lat[3] - lat[2]), 32'h0, "delay code 10");
    $display("test delay done");
  endtask

  // main sequence
  initial
  begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_edge();
    t_level();
    t_timer();
    t_delay();
    end_of_test();
  end

  // watchdog: the run needs well under a thousand cycles
  initial
  begin
    #200000;
    n_fail++;
    $display("BAD %0t watchdog expired", $time);
    end_of_test();
  end
endmodule
